// ### mua_pkg.sv
// Purpose: Shared constants and types of the management user access block.
// Assumes: 20 MHz system clock; APB register bus with byte addresses.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package mua_pkg;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_ALIVE = 8'h08;
	localparam logic [7:0] OFS_LINK = 8'h0c;
	localparam logic [7:0] OFS_LINK_RAW = 8'h10;
	localparam logic [7:0] OFS_LINK_MSK = 8'h14;
	localparam logic [7:0] OFS_DONE_RAW = 8'h20;
	localparam logic [7:0] OFS_DONE_MSK = 8'h24;
	localparam logic [7:0] OFS_EN_SET = 8'h28;
	localparam logic [7:0] OFS_EN_CLR = 8'h2c;
	localparam logic [7:0] OFS_ACC0 = 8'h80;
	localparam logic [7:0] OFS_SEL0 = 8'h84;
	localparam logic [7:0] OFS_ACC1 = 8'h88;
	localparam logic [7:0] OFS_SEL1 = 8'h8c;
	localparam int LAUNCH_BIT = 31;
	localparam int WRITE_BIT = 30;
	localparam int ACK_BIT = 29;
	localparam int REG_LSB = 21;
	localparam int PHY_LSB = 16;
	localparam int LSEL_BIT = 7;
	localparam int LIEN_BIT = 6;
	localparam int CTL_IDLE_BIT = 31;
	localparam int CTL_EN_BIT = 30;
	localparam int CTL_TEST_BIT = 17;
	localparam logic [31:0] ACC_RW_MASK = 32'he3ff_ffff;
	localparam logic [31:0] SEL_RW_MASK = 32'h0000_00df;
	localparam logic [31:0] CTL_RW_MASK = 32'h4002_0000;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [4:0] STATUS_REG_INDEX = 5'h01;
	localparam int LINK_UP_BIT = 2;
	localparam int CLK_MHZ = 20;
	localparam int MDC_HALF_NS = 200;
	localparam int MDC_HALF_CYC = (MDC_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int FRAME_BITS = 64;
	localparam int RD_RELEASE_BIT = 46;
	localparam int ACK_SAMPLE_BIT = 47;
	localparam int DATA_FIRST_BIT = 48;
	typedef enum logic [0:0] {MUA_IDLE, MUA_RUN} mua_state_t;
endpackage

// ### mua_frame.sv
// Purpose: Shifts one management frame out on the serial pins.
// Assumes: Start arrives only while no frame is running.
// Notes: The clock pin is divided from the system clock.
`timescale 1ns/1ps
module mua_frame (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [4:0] phy_i,
	input wire logic [4:0] reg_i,
	input wire logic [15:0] wdata_i,
	input wire logic mdio_i,
	output logic done_o,
	output logic ack_o,
	output logic [15:0] rdata_o,
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_o
);
	logic [63:0] shift_q;
	logic [6:0] bit_q;
	logic [2:0] div_q;
	logic busy_q;
	logic rd_q;
	logic s1_q;
	logic s2_q;
	logic [63:0] frame_w;
	logic tick_w;
	logic [6:0] nxt_w;

	// Preamble, start, opcode, addresses, turnaround, data.
	assign frame_w = {32'hffff_ffff, 2'b01, write_i ? 2'b01 : 2'b10,
		phy_i, reg_i, write_i ? 2'b10 : 2'b00,
		write_i ? wdata_i : 16'h0000};
	assign tick_w = div_q == 3'(mua_pkg::MDC_HALF_CYC - 1);
	assign nxt_w = bit_q + 7'h01;
	assign mdio_o = shift_q[63];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
		end else begin
			s1_q <= mdio_i;
			s2_q <= s1_q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shift_q <= 64'h0;
			bit_q <= 7'h00;
			div_q <= 3'h0;
			busy_q <= 1'b0;
			rd_q <= 1'b0;
			done_o <= 1'b0;
			ack_o <= 1'b0;
			rdata_o <= 16'h0000;
			mdc_o <= 1'b0;
			mdio_oe_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!busy_q) begin
				if (start_i) begin
					shift_q <= frame_w;
					bit_q <= 7'h00;
					div_q <= 3'h0;
					busy_q <= 1'b1;
					rd_q <= ~write_i;
					ack_o <= 1'b0;
					mdc_o <= 1'b0;
					mdio_oe_o <= 1'b1;
				end
			end else if (!tick_w) begin
				div_q <= div_q + 3'h1;
			end else begin
				div_q <= 3'h0;
				mdc_o <= ~mdc_o;
				if (!mdc_o) begin
					// Sampled on the rising edge the PHY answers to.
					if (rd_q && bit_q == 7'(mua_pkg::ACK_SAMPLE_BIT))
						ack_o <= ~s2_q;
					if (rd_q && bit_q >= 7'(mua_pkg::DATA_FIRST_BIT))
						rdata_o <= {rdata_o[14:0], s2_q};
				end else if (bit_q == 7'(mua_pkg::FRAME_BITS - 1)) begin
					busy_q <= 1'b0;
					done_o <= 1'b1;
					mdio_oe_o <= 1'b0;
				end else begin
					bit_q <= nxt_w;
					shift_q <= {shift_q[62:0], 1'b1};
					// The PHY owns the pin from turnaround on a read.
					mdio_oe_o <= ~(rd_q &&
						nxt_w >= 7'(mua_pkg::RD_RELEASE_BIT));
				end
			end
		end
	end
endmodule

// ### mua_top.sv
// Purpose: User access channels and event flags of a management controller.
// Assumes: APB slave with zero wait states; one clock and reset.
// Notes: Polling engine and clock divider register are not built here.
// Functional notes
// - Raw done flag per channel, bit 0 channel 0, set on completion.
// - Writing 1 clears a raw done flag; 0 leaves it.
// - With test enable, writing 1 sets raw done flags.
// - Masked done bit is raw done AND that channel's enable.
// - Writing 1 to a masked done bit clears the pending event.
// - With test enable, writing 1 to masked done bits sets the raw flags.
// - Enable-set writes of 1 enable a channel; 0 leaves its enable unchanged.
// - Enable-clear writes of 1 disable a channel's done events.
// - Writing 1 to bit 31 queues a transaction; 0 does nothing.
// - Launch bit accepts 1 only while the engine is enabled.
// - Launch bit clears itself when its transaction finishes.
// - While launch reads 1, all writes to that access word are blocked.
// - Bit 30 picks transaction type: 1 write, 0 read.
// - Bit 29 is set when the PHY acknowledged the read.
// - Register index bits 25-21, PHY index bits 20-16.
// - Bits 15-0 hold write data, then the read result.
// - Select bit 7 picks link source: pin or engine result.
// - Select bit 6 enables link change events of that channel.
// - Select bits 4-0 hold the watched PHY index.
// - Disabled engine finishes the running frame, then shows idle.
// - Raw link change flag per channel on a watched link change.
// - Masked link change bit is raw event AND its enable.
// - User reads update the PHY presence flag from its acknowledge.
`timescale 1ns/1ps
module mua_top (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [1:0] external_link_input_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_o,
	output logic mdc_o
);
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb,
		input logic [31:0] msk);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r & msk;
	endfunction

	function automatic logic [1:0] ones(input logic hit,
		input logic [31:0] d, input logic [3:0] strb);
		return (hit && strb[0]) ? d[1:0] : 2'b00;
	endfunction

	logic [31:0] acc_q [2];
	logic [31:0] sel_q [2];
	logic [31:0] ctl_q;
	logic [31:0] alive_q;
	logic [31:0] link_q;
	logic [1:0] cmd_done_raw_flags_q;
	logic [1:0] cmd_done_enable_q;
	logic [1:0] link_change_raw_flags_q;
	logic [1:0] lprev_q;
	logic [1:0] ext1_q;
	logic [1:0] ext2_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	mua_pkg::mua_state_t state_q;
	logic ch_q;
	logic start_q;

	logic fr_done;
	logic fr_ack;
	logic [15:0] fr_rdata;

	wire setup_w = psel_i & ~penable_i;
	wire wr_w = psel_i & penable_i & pready_q & pwrite_i;
	wire h_ctl = paddr_i == mua_pkg::OFS_CONTROL;
	wire h_alive = paddr_i == mua_pkg::OFS_ALIVE;
	wire h_link = paddr_i == mua_pkg::OFS_LINK;
	wire h_lraw = paddr_i == mua_pkg::OFS_LINK_RAW;
	wire h_lmsk = paddr_i == mua_pkg::OFS_LINK_MSK;
	wire h_draw = paddr_i == mua_pkg::OFS_DONE_RAW;
	wire h_dmsk = paddr_i == mua_pkg::OFS_DONE_MSK;
	wire h_eset = paddr_i == mua_pkg::OFS_EN_SET;
	wire h_eclr = paddr_i == mua_pkg::OFS_EN_CLR;
	wire h_acc0 = paddr_i == mua_pkg::OFS_ACC0;
	wire h_sel0 = paddr_i == mua_pkg::OFS_SEL0;
	wire h_acc1 = paddr_i == mua_pkg::OFS_ACC1;
	wire h_sel1 = paddr_i == mua_pkg::OFS_SEL1;
	wire mapped_w = h_ctl | h_alive | h_link | h_lraw | h_lmsk |
		h_draw | h_dmsk | h_eset | h_eclr | h_acc0 | h_sel0 |
		h_acc1 | h_sel1;

	wire enable_w = ctl_q[mua_pkg::CTL_EN_BIT];
	wire test_w = ctl_q[mua_pkg::CTL_TEST_BIT];
	wire idle_w = state_q == mua_pkg::MUA_IDLE;
	wire [1:0] launch_w = {acc_q[1][mua_pkg::LAUNCH_BIT],
		acc_q[0][mua_pkg::LAUNCH_BIT]};
	wire [1:0] lien_w = {sel_q[1][mua_pkg::LIEN_BIT],
		sel_q[0][mua_pkg::LIEN_BIT]};

	// Fixed order keeps channel 1 waiting while channel 0 is busy.
	wire pick_w = ~launch_w[0];
	wire [31:0] cur_w = acc_q[ch_q];
	wire cur_wr_w = cur_w[mua_pkg::WRITE_BIT];
	wire [4:0] target_reg_index = cur_w[mua_pkg::REG_LSB +: 5];
	wire [4:0] target_phy_index = cur_w[mua_pkg::PHY_LSB +: 5];

	wire [1:0] cmd_done_masked_flags =
		cmd_done_raw_flags_q & cmd_done_enable_q;
	wire [1:0] link_change_masked_flags =
		link_change_raw_flags_q & lien_w;

	wire [1:0] draw_w1 = ones(wr_w & h_draw, pwdata_i, pstrb_i);
	wire [1:0] dmsk_w1 = ones(wr_w & h_dmsk, pwdata_i, pstrb_i);
	wire [1:0] lraw_w1 = ones(wr_w & h_lraw, pwdata_i, pstrb_i);
	wire [1:0] lmsk_w1 = ones(wr_w & h_lmsk, pwdata_i, pstrb_i);
	wire [1:0] eset_w1 = ones(wr_w & h_eset, pwdata_i, pstrb_i);
	wire [1:0] eclr_w1 = ones(wr_w & h_eclr, pwdata_i, pstrb_i);

	wire [1:0] done_set_w = fr_done ? (ch_q ? 2'b10 : 2'b01) : 2'b00;
	wire [1:0] draw_tst_w = test_w ? (draw_w1 | dmsk_w1) : 2'b00;
	wire [1:0] lraw_tst_w = test_w ? (lraw_w1 | lmsk_w1) : 2'b00;

	// Link state of each channel from the pin or the engine's table.
	wire [1:0] lcur_w;
	assign lcur_w[0] = sel_q[0][mua_pkg::LSEL_BIT] ? ext2_q[0] :
		link_q[sel_q[0][4:0]];
	assign lcur_w[1] = sel_q[1][mua_pkg::LSEL_BIT] ? ext2_q[1] :
		link_q[sel_q[1][4:0]];
	wire [1:0] lchg_w = lcur_w ^ lprev_q;

	wire [31:0] ctl_rd_w = ctl_q |
		({31'h0, idle_w} << mua_pkg::CTL_IDLE_BIT);
	wire [31:0] rd_w =
		h_ctl ? ctl_rd_w :
		h_alive ? alive_q :
		h_link ? link_q :
		h_lraw ? {30'h0, link_change_raw_flags_q} :
		h_lmsk ? {30'h0, link_change_masked_flags} :
		h_draw ? {30'h0, cmd_done_raw_flags_q} :
		h_dmsk ? {30'h0, cmd_done_masked_flags} :
		(h_eset | h_eclr) ? {30'h0, cmd_done_enable_q} :
		h_acc0 ? acc_q[0] :
		h_sel0 ? sel_q[0] :
		h_acc1 ? acc_q[1] :
		h_sel1 ? sel_q[1] : mua_pkg::RESET_WORD;

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;

	mua_frame u_frame (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.start_i(start_q),
		.write_i(cur_wr_w),
		.phy_i(target_phy_index),
		.reg_i(target_reg_index),
		.wdata_i(cur_w[15:0]),
		.mdio_i(mdio_i),
		.done_o(fr_done),
		.ack_o(fr_ack),
		.rdata_o(fr_rdata),
		.mdc_o(mdc_o),
		.mdio_o(mdio_o),
		.mdio_oe_o(mdio_oe_o)
	);

	// Zero wait states: one access cycle follows each setup cycle.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= mua_pkg::RESET_WORD;
		end else begin
			pready_q <= setup_w;
			pslverr_q <= setup_w & ~mapped_w;
			prdata_q <= (setup_w & ~pwrite_i) ? rd_w : mua_pkg::RESET_WORD;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ext1_q <= 2'b00;
			ext2_q <= 2'b00;
			lprev_q <= 2'b00;
		end else begin
			ext1_q <= external_link_input_i;
			ext2_q <= ext1_q;
			lprev_q <= lcur_w;
		end
	end

	// A set in the same cycle as a clear wins, so no event is lost.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_done_raw_flags_q <= 2'b00;
			link_change_raw_flags_q <= 2'b00;
			cmd_done_enable_q <= 2'b00;
		end else begin
			cmd_done_raw_flags_q <= (cmd_done_raw_flags_q &
				~(draw_w1 | dmsk_w1)) | draw_tst_w |
				done_set_w;
			link_change_raw_flags_q <= (link_change_raw_flags_q &
				~(lraw_w1 | lmsk_w1)) | lraw_tst_w | lchg_w;
			cmd_done_enable_q <= (cmd_done_enable_q | eset_w1) &
				~eclr_w1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctl_q <= mua_pkg::RESET_WORD;
			sel_q[0] <= mua_pkg::RESET_WORD;
			sel_q[1] <= mua_pkg::RESET_WORD;
		end else begin
			if (wr_w & h_ctl)
				ctl_q <= merge(ctl_q, pwdata_i, pstrb_i, mua_pkg::CTL_RW_MASK);
			if (wr_w & h_sel0)
				sel_q[0] <= merge(sel_q[0], pwdata_i, pstrb_i,
					mua_pkg::SEL_RW_MASK);
			if (wr_w & h_sel1)
				sel_q[1] <= merge(sel_q[1], pwdata_i, pstrb_i,
					mua_pkg::SEL_RW_MASK);
		end
	end

	// Launch is in the top byte, so a byte write of it comes last.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			acc_q[0] <= mua_pkg::RESET_WORD;
			acc_q[1] <= mua_pkg::RESET_WORD;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (wr_w && (c == 0 ? h_acc0 : h_acc1) &&
					!launch_w[c]) begin
					acc_q[c] <= merge(acc_q[c], pwdata_i, pstrb_i,
						mua_pkg::ACC_RW_MASK);
					acc_q[c][mua_pkg::LAUNCH_BIT] <= pstrb_i[3] &
						pwdata_i[mua_pkg::LAUNCH_BIT] &
						enable_w;
				end else if (fr_done && ch_q == c[0]) begin
					acc_q[c][mua_pkg::LAUNCH_BIT] <= 1'b0;
					if (!acc_q[c][mua_pkg::WRITE_BIT]) begin
						acc_q[c][mua_pkg::ACK_BIT] <= fr_ack;
						acc_q[c][15:0] <= fr_rdata;
					end
				end
			end
		end
	end

	// Presence follows each completed user read; the link table only reads of the status register.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			alive_q <= mua_pkg::RESET_WORD;
			link_q <= mua_pkg::RESET_WORD;
		end else begin
			if (wr_w & h_alive)
				alive_q <= alive_q & ~pwdata_i;
			if (fr_done && !cur_wr_w) begin
				alive_q[target_phy_index] <= fr_ack;
				if (target_reg_index == mua_pkg::STATUS_REG_INDEX)
					link_q[target_phy_index] <= fr_ack &
						fr_rdata[mua_pkg::LINK_UP_BIT];
			end
		end
	end

	// Disabling stops new launches only; a running frame completes.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= mua_pkg::MUA_IDLE;
			ch_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			case (state_q)
				mua_pkg::MUA_IDLE: begin
					if (enable_w && launch_w != 2'b00) begin
						ch_q <= pick_w;
						start_q <= 1'b1;
						state_q <= mua_pkg::MUA_RUN;
					end
				end
				mua_pkg::MUA_RUN: begin
					if (fr_done)
						state_q <= mua_pkg::MUA_IDLE;
				end
				default: state_q <= mua_pkg::MUA_IDLE;
			endcase
		end
	end
endmodule

// ### mua_top_assertions.sv
// Purpose: Port-level checks of the management user access block.
// Assumes: Zero wait-state APB slave and 4+4 cycle serial clock.
// Notes: Bound to the top module from the test top.
`timescale 1ns/1ps
module mua_top_assertions (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic mdio_o,
	input wire logic mdio_oe_o,
	input wire logic mdc_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wire logic rd_ack = pready_o && !pwrite_i;
	wire logic mapped = paddr_i inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
		8'h20, 8'h24, 8'h28, 8'h2c, 8'h80, 8'h84, 8'h88, 8'h8c};
	property p_ready_after_setup;
		psel_i && !penable_i |=> pready_o;
	endproperty
	property p_ready_pulse;
		pready_o |=> !pready_o;
	endproperty
	property p_err_map;
		pready_o |-> pslverr_o == !mapped;
	endproperty
	property p_rdata_idle;
		!rd_ack |-> prdata_o == 32'h0;
	endproperty
	property p_raw_rsvd;
		rd_ack && paddr_i == 8'h20 |-> prdata_o[31:2] == 30'h0;
	endproperty
	property p_msk_rsvd;
		rd_ack && paddr_i == 8'h24 |-> prdata_o[31:2] == 30'h0;
	endproperty
	property p_sel_rsvd;
		rd_ack && (paddr_i == 8'h84 || paddr_i == 8'h8c)
			|-> prdata_o[31:8] == 24'h0 && !prdata_o[5];
	endproperty
	property p_acc_rsvd;
		rd_ack && (paddr_i == 8'h80 || paddr_i == 8'h88)
			|-> prdata_o[28:26] == 3'h0;
	endproperty
	property p_mdc_high;
		$rose(mdc_o) |-> mdc_o [*4] ##1 !mdc_o;
	endproperty
	property p_mdc_low;
		$fell(mdc_o) |-> !mdc_o [*4];
	endproperty
	// Data must not move while the far side may be sampling it.
	property p_data_stable;
		mdc_o && $past(mdc_o) |-> $stable(mdio_o) && $stable(mdio_oe_o);
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup)
		else $error("no ready one cycle after setup");
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready held longer than one cycle");
	a_err_map: assert property (p_err_map)
		else $error("slave error does not match address map");
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside read access");
	a_raw_rsvd: assert property (p_raw_rsvd)
		else $error("raw done reserved bits set");
	a_msk_rsvd: assert property (p_msk_rsvd)
		else $error("masked done reserved bits set");
	a_sel_rsvd: assert property (p_sel_rsvd)
		else $error("select reserved bits set");
	a_acc_rsvd: assert property (p_acc_rsvd)
		else $error("access word reserved bits set");
	a_mdc_high: assert property (p_mdc_high)
		else $error("serial clock high phase wrong");
	a_mdc_low: assert property (p_mdc_low)
		else $error("serial clock low phase too short");
	a_data_stable: assert property (p_data_stable)
		else $error("serial data moved while clock high");
	c_read_release: cover property ($fell(mdio_oe_o));
	c_slverr: cover property (pslverr_o);
	c_frame: cover property ($rose(mdc_o));
endmodule

// ### mua_phy_model.sv
// Purpose: Behavioural PHY that answers management frames at one address.
// Assumes: Every frame is 64 clock bits and starts with the preamble.
// Notes: A released line is pulled high by the bench.
`timescale 1ns/1ps
module mua_phy_model #(
	parameter logic [4:0] PHY_ADDR = 5'h03
) (
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic drive_o,
	output logic data_o
);
	logic [15:0] regs [32];
	logic [15:0] rd;
	logic [63:0] sr;
	int cnt = 0;
	initial begin
		for (int i = 0; i < 32; i++) begin
			regs[i] = 16'ha500 + 16'(i);
		end
		drive_o = 1'b0;
		data_o = 1'b1;
	end
	// Counting whole frames loses sync after a reset in mid-frame.
	always @(posedge mdc_i) begin
		if (cnt == 64)
			cnt = 0;
		sr = {sr[62:0], mdio_i};
		cnt++;
		if (cnt == 64 && sr[29:28] == 2'h1 && sr[27:23] == PHY_ADDR)
			regs[sr[22:18]] = sr[15:0];
	end
	// First turnaround bit stays released; the second acknowledges.
	always @(negedge mdc_i) begin
		if (cnt == 47 && sr[12:11] == 2'h2 && sr[10:6] == PHY_ADDR) begin
			rd = regs[sr[5:1]];
			drive_o = 1'b1;
			data_o = 1'b0;
		end else if (drive_o && cnt < 64) begin
			data_o = rd[63 - cnt];
		end else begin
			drive_o = 1'b0;
		end
	end
endmodule

// ### mdio_user_access_and_irq_test.sv
// Purpose: Self-checking bench of the management user access block.
// Assumes: PHY model answers at address 3; nothing answers at 7.
// Notes: Register cases run from a table; serial cases follow it.
`timescale 1ns/1ps
module mdio_user_access_and_irq_test;
	typedef struct packed {
		logic [7:0] wa;
		logic [31:0] wd;
		logic [7:0] ra;
		logic [31:0] x;
	} mua_row_t;
	logic clk_i, rst_b_i, psel_i, penable_i, pwrite_i, er_v;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd_v;
	logic [3:0] pstrb_i;
	logic pready_o, pslverr_o, mdio_o, mdio_oe_o, mdc_o, phy_drv, phy_dat;
	logic [1:0] link_pins;
	wire logic line_lvl;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	mua_row_t rows [14];
	assign line_lvl = mdio_oe_o ? mdio_o : (phy_drv ? phy_dat : 1'b1);
	mua_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o),
		.external_link_input_i(link_pins), .mdio_i(line_lvl),
		.mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .mdc_o(mdc_o));
	mua_phy_model i_phy (.mdc_i(mdc_o), .mdio_i(line_lvl),
		.drive_o(phy_drv), .data_o(phy_dat));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			summarize();
		end
	end
	// Request held until ready is seen at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= s;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd_v = prdata_o;
		er_v = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, 4'h0);
		total_checks++;
		if (rd_v !== x) begin
			n_errors++;
			$display("unexpected reg %h: expected %h seen %h", a, x, rd_v);
		end
	endtask
	task automatic wait_idle(input logic [7:0] a);
		do apb(1'b0, a, 32'h0, 4'h0); while (rd_v[31] !== 1'b0);
	endtask
	initial begin
		rst_b_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		pstrb_i = 4'h0;
		link_pins = 2'h0;
		rows = '{
			'{8'h84, 32'hffff_ffff, 8'h84, 32'h0000_00df},
			'{8'h8c, 32'h0000_00c5, 8'h8c, 32'h0000_00c5},
			'{8'h28, 32'h0000_0003, 8'h28, 32'h0000_0003},
			'{8'h2c, 32'h0000_0001, 8'h28, 32'h0000_0002},
			'{8'h28, 32'h0000_0000, 8'h2c, 32'h0000_0002},
			'{8'h04, 32'h4002_0000, 8'h04, 32'hc002_0000},
			'{8'h24, 32'h0000_0001, 8'h20, 32'h0000_0001},
			'{8'h20, 32'h0000_0002, 8'h20, 32'h0000_0003},
			'{8'h20, 32'h0000_0000, 8'h24, 32'h0000_0002},
			'{8'h04, 32'h4000_0000, 8'h04, 32'hc000_0000},
			'{8'h20, 32'h0000_0001, 8'h20, 32'h0000_0002},
			'{8'h24, 32'h0000_0002, 8'h20, 32'h0000_0000},
			'{8'h20, 32'h0000_0002, 8'h20, 32'h0000_0000},
			'{8'h80, 32'h7fff_ffff, 8'h80, 32'h63ff_ffff}};
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			chk(rows[i].ra, rows[i].x);
		end
		$display("table done");
		wr(8'h04, 32'h0);
		wr(8'h80, 32'h8000_1234);
		chk(8'h80, 32'h0000_1234);
		wr(8'h04, 32'h4000_0000);
		apb(1'b1, 8'h80, 32'h0063_beef, 4'h7);
		apb(1'b1, 8'h80, 32'hc000_0000, 4'h8);
		wr(8'h80, 32'h0);
		chk(8'h80, 32'hc063_beef);
		wait_idle(8'h80);
		chk(8'h80, 32'h4063_beef);
		chk(8'h20, 32'h0000_0001);
		$display("write frame done");
		wr(8'h80, 32'h8063_0000);
		wr(8'h88, 32'h8027_0000);
		wait_idle(8'h80);
		chk(8'h88, 32'h8027_0000);
		chk(8'h80, 32'h2063_beef);
		wait_idle(8'h88);
		chk(8'h88, 32'h0027_ffff);
		chk(8'h08, 32'h0000_0008);
		chk(8'h20, 32'h0000_0003);
		$display("read frames done");
		wr(8'h80, 32'h8063_0000);
		wr(8'h04, 32'h0);
		wait_idle(8'h80);
		chk(8'h04, 32'h8000_0000);
		$display("disable done");
		wr(8'h84, 32'h0000_00c3);
		wr(8'h8c, 32'h0000_0087);
		wr(8'h10, 32'h0000_0003);
		link_pins <= 2'h3;
		repeat (6) @(posedge clk_i);
		chk(8'h10, 32'h0000_0003);
		chk(8'h14, 32'h0000_0001);
		apb(1'b0, 8'h40, 32'h0, 4'h0);
		total_checks++;
		if ({er_v, rd_v} !== 33'h1_0000_0000) begin
			n_errors++;
			$display("unexpected slverr: expected 1 seen %h", er_v);
		end
		$display("link and map done");
		// Channel 1 now watches the engine's table entry of PHY 3.
		wr(8'h04, 32'h4000_0000);
		wr(8'h8c, 32'h0000_0043);
		wr(8'h88, 32'hc023_0004);
		wait_idle(8'h88);
		wr(8'h10, 32'h0000_0003);
		wr(8'h88, 32'h8023_0000);
		wait_idle(8'h88);
		chk(8'h0c, 32'h0000_0008);
		chk(8'h14, 32'h0000_0002);
		$display("engine link done");
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		chk(8'h84, 32'h0);
		chk(8'h80, 32'h0);
		chk(8'h04, 32'h8000_0000);
		chk(8'h28, 32'h0);
		chk(8'h20, 32'h0);
		$display("reset done");
		summarize();
	end
endmodule
bind mua_top mua_top_assertions i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
	.mdc_o(mdc_o));
